// File: rtl/palette_snoop_pkg.sv
// Shared constants and types for the palette write snooper
package palette_snoop_pkg;

	// Bus command codes as seen on the active-high command lines
	localparam logic [3:0] CMD_IO_READ  = 4'h2;
	localparam logic [3:0] CMD_IO_WRITE = 4'h3;
	localparam logic [3:0] CMD_DUAL_ADR = 4'hD;

	// Palette port window in I/O space, inclusive bounds
	localparam logic [31:0] PAL_LO_ADDR = 32'h0000_03C6;
	localparam logic [31:0] PAL_HI_ADDR = 32'h0000_03C9;

	// Reset values
	localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
	localparam logic [3:0]  BE_RESET    = 4'hF;

	// Tracker states
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_XFER = 1'b1
	} snoop_state_type;

	// One captured palette write
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0]  be_n;
		logic        by_abort;
	} snoop_capture_type;

endpackage : palette_snoop_pkg

// File: rtl/palette_addr_decode.sv
// Address phase decoder for palette reads and writes
`timescale 1ns/100ps
`default_nettype none
module palette_addr_decode
	import palette_snoop_pkg::*;
#(
	parameter logic [31:0] LO_ADDR = PAL_LO_ADDR,
	parameter logic [31:0] HI_ADDR = PAL_HI_ADDR
) (
	input  wire logic [31:0] addr_in,
	input  wire logic [3:0]  cmd_in,
	output wire logic        pal_wr_out,
	output wire logic        pal_rd_out
);

	// Range check; a dual address cycle is never a palette port
	wire logic in_range;
	assign in_range   = (addr_in >= LO_ADDR) && (addr_in <= HI_ADDR);
	assign pal_wr_out = in_range && (cmd_in == CMD_IO_WRITE);
	assign pal_rd_out = in_range && (cmd_in == CMD_IO_READ);

endmodule : palette_addr_decode
`default_nettype wire

// File: rtl/palette_write_snoop.sv
// Passive palette write snooper for one shared bus segment
//
// What this block does
// - When snooping, a normal (non-abort) capture is taken only on an edge where initiator ready and target ready are both seen asserted.
// - A snooped palette write that ends in Master-Abort is also captured.
// - The snooper drives no bus signal and follows whatever master and target do.
// - Each captured write is taken at once with no wait state and no back-pressure.
// - The active display adapter always claims palette reads; read_claim_out only flags the claim and no read data is driven.
// - One device claims palette writes while the other only snoops and never asserts device select.
// - Snooping happens only while the palette snoop enable bit is set.
// - Only transactions on this device's own segment are seen and captured.
// - On an illegal protocol event the tracker returns to idle at once.
`timescale 1ns/100ps
`default_nettype none
module palette_write_snoop
	import palette_snoop_pkg::*;
#(
	parameter logic [31:0] LO_ADDR = PAL_LO_ADDR,
	parameter logic [31:0] HI_ADDR = PAL_HI_ADDR
) (
	input  wire logic              mclk_in,
	input  wire logic              rst_n_in,
	input  wire logic              frame_n_in,
	input  wire logic              irdy_n_in,
	input  wire logic              trdy_n_in,
	input  wire logic              devsel_n_in,
	input  wire logic [31:0]       ad_in,
	input  wire logic [3:0]        cbe_n_in,
	input  wire logic              snoop_en_in,
	input  wire logic              write_claimer_in,
	input  wire logic              adapter_active_in,
	output var  snoop_capture_type capture_out,
	output logic                   capture_valid_out,
	output logic                   read_claim_out,
	output logic                   write_claim_out,
	output logic                   protocol_err_out
);

	// Tracker and capture state
	snoop_state_type   state_q, state_d;
	snoop_capture_type cap_q, cap_d;
	logic              cap_valid_q, cap_valid_d;
	logic              hit_q, hit_d;
	logic              dev_seen_q, dev_seen_d;
	logic              frame_off_q, frame_off_d;
	logic              frame_n_q;
	logic [31:0]       addr_q, addr_d;
	logic [31:0]       shadow_data_q, shadow_data_d;
	logic [3:0]        shadow_be_q, shadow_be_d;
	logic              shadow_ok_q, shadow_ok_d;
	logic              rd_claim_q, rd_claim_d;
	logic              wr_claim_q, wr_claim_d;
	logic              err_q, err_d;

	// Decoded bus qualifiers; every input is a local segment sample
	wire logic       start;
	wire logic       data_xfer;
	wire logic       bus_done;
	wire logic       illegal;
	wire logic       idle_irdy;
	wire logic       pal_wr;
	wire logic       pal_rd;
	wire logic       snoop_on;
	wire logic       ab_end;
	wire logic [3:0] cmd;

	assign cmd       = ~cbe_n_in;
	// Address phase: frame newly asserted while tracker idles
	assign start     = (state_q == ST_IDLE) && !frame_n_in && frame_n_q;
	assign data_xfer = (state_q == ST_XFER) && !irdy_n_in && !trdy_n_in;
	assign bus_done  = (state_q == ST_XFER) && frame_n_in && irdy_n_in;
	// Frame coming back after release inside one transaction
	assign illegal   = (state_q == ST_XFER) && frame_off_q && !frame_n_in;
	assign idle_irdy = (state_q == ST_IDLE) && !irdy_n_in && frame_n_in;
	// Claiming device does not snoop, snooper never claims
	assign snoop_on  = snoop_en_in && !write_claimer_in;
	// Write ended with nobody claiming it: Master-Abort
	assign ab_end    = bus_done && hit_q && !dev_seen_q && shadow_ok_q;

	palette_addr_decode #(
		.LO_ADDR (LO_ADDR),
		.HI_ADDR (HI_ADDR)
	) u_decode (
		.addr_in    (ad_in),
		.cmd_in     (cmd),
		.pal_wr_out (pal_wr),
		.pal_rd_out (pal_rd)
	);

	// Next state; no path here ever stalls the bus
	always_comb begin
		state_d       = state_q;
		hit_d         = hit_q;
		addr_d        = addr_q;
		dev_seen_d    = dev_seen_q;
		frame_off_d   = frame_off_q;
		shadow_data_d = shadow_data_q;
		shadow_be_d   = shadow_be_q;
		shadow_ok_d   = shadow_ok_q;
		cap_d         = cap_q;
		cap_valid_d   = 1'b0;
		rd_claim_d    = 1'b0;
		wr_claim_d    = 1'b0;
		err_d         = idle_irdy;
		unique case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_d     = ST_XFER;
					hit_d       = pal_wr && snoop_on;
					addr_d      = ad_in;
					dev_seen_d  = 1'b0;
					frame_off_d = 1'b0;
					shadow_ok_d = 1'b0;
					rd_claim_d  = pal_rd && adapter_active_in;
					wr_claim_d  = pal_wr && write_claimer_in;
				end
			end
			ST_XFER: begin
				if (!devsel_n_in) begin
					dev_seen_d = 1'b1;
				end
				if (frame_n_in) begin
					frame_off_d = 1'b1;
				end
				// Last data the master offered, kept for an abort
				if (!irdy_n_in) begin
					shadow_data_d = ad_in;
					shadow_be_d   = cbe_n_in;
					shadow_ok_d   = 1'b1;
				end
				// Capture in the same edge, nothing to push back
				if (data_xfer && hit_q) begin
					cap_d       = '{addr: addr_q, data: ad_in,
						be_n: cbe_n_in, by_abort: 1'b0};
					cap_valid_d = 1'b1;
				end
				if (illegal) begin
					state_d = ST_IDLE;
					hit_d   = 1'b0;
					err_d   = 1'b1;
				end else if (bus_done) begin
					state_d = ST_IDLE;
					hit_d   = 1'b0;
					if (ab_end) begin
						cap_d       = '{addr: addr_q, data: shadow_data_q,
							be_n: shadow_be_q, by_abort: 1'b1};
						cap_valid_d = 1'b1;
					end
				end
			end
		endcase
	end

	// Tracker flops
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q     <= ST_IDLE;
			hit_q       <= 1'b0;
			dev_seen_q  <= 1'b0;
			frame_off_q <= 1'b0;
			frame_n_q   <= 1'b1;
			addr_q      <= DATA_RESET;
		end else begin
			state_q     <= state_d;
			hit_q       <= hit_d;
			dev_seen_q  <= dev_seen_d;
			frame_off_q <= frame_off_d;
			frame_n_q   <= frame_n_in;
			addr_q      <= addr_d;
		end
	end

	// Shadow of the last offered data word
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shadow_data_q <= DATA_RESET;
			shadow_be_q   <= BE_RESET;
			shadow_ok_q   <= 1'b0;
		end else begin
			shadow_data_q <= shadow_data_d;
			shadow_be_q   <= shadow_be_d;
			shadow_ok_q   <= shadow_ok_d;
		end
	end

	// Output flops; the capture word holds until the next capture
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cap_q       <= '{addr: DATA_RESET, data: DATA_RESET,
				be_n: BE_RESET, by_abort: 1'b0};
			cap_valid_q <= 1'b0;
			rd_claim_q  <= 1'b0;
			wr_claim_q  <= 1'b0;
			err_q       <= 1'b0;
		end else begin
			cap_q       <= cap_d;
			cap_valid_q <= cap_valid_d;
			rd_claim_q  <= rd_claim_d;
			wr_claim_q  <= wr_claim_d;
			err_q       <= err_d;
		end
	end

	assign capture_out       = cap_q;
	assign capture_valid_out = cap_valid_q;
	assign read_claim_out    = rd_claim_q;
	assign write_claim_out   = wr_claim_q;
	assign protocol_err_out  = err_q;

	// Checks on the tracker and capture path
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	AST_CAP_ON_HANDSHAKE: assert property (
		cap_valid_q && !cap_q.by_abort |->
		$past(!irdy_n_in && !trdy_n_in && state_q == ST_XFER && hit_q))
		else $error("normal capture without ready handshake");

	AST_ABORT_CAPTURE: assert property (
		bus_done && hit_q && !dev_seen_q && shadow_ok_q |=>
		capture_valid_out && capture_out.by_abort &&
		capture_out.data == $past(shadow_data_q))
		else $error("master abort write not captured");

	AST_NO_STALL: assert property (
		data_xfer && hit_q |=> capture_valid_out &&
		capture_out.data == $past(ad_in))
		else $error("handshake data not taken at once");

	AST_READ_CLAIM: assert property (
		start && pal_rd && adapter_active_in |=> read_claim_out)
		else $error("active adapter did not claim palette read");

	AST_CLAIMER_NO_SNOOP: assert property (
		start && write_claimer_in |=> !hit_q ##1 !capture_valid_out)
		else $error("claiming device also snooped");

	AST_DISABLED_QUIET: assert property (
		start && !snoop_en_in |=> !hit_q)
		else $error("snoop armed while disabled");

	AST_ILLEGAL_IDLE: assert property (
		illegal |=> state_q == ST_IDLE && protocol_err_out)
		else $error("illegal event did not force idle");

	AST_READ_NOT_SNOOPED: assert property (
		start && cmd == CMD_IO_READ |=> !hit_q)
		else $error("palette read armed the snooper");

	COV_NORMAL: cover property (capture_valid_out && !capture_out.by_abort);
	COV_ABORT: cover property (capture_valid_out && capture_out.by_abort);
	COV_READ_CLAIM: cover property (read_claim_out);
	COV_ILLEGAL: cover property (illegal);

endmodule : palette_write_snoop
`default_nettype wire

// File: tb/bus_agent_model.sv
// Master and claiming target model for the observed bus segment
`timescale 1ns/100ps
`default_nettype none
module bus_agent_model (
	input  wire logic        clk_in,
	output logic             frame_n_out,
	output logic             irdy_n_out,
	output logic             trdy_n_out,
	output logic             devsel_n_out,
	output logic [31:0]      ad_out,
	output logic [3:0]       cbe_n_out
);
	// Idle bus at time zero
	initial begin
		{frame_n_out, irdy_n_out, trdy_n_out, devsel_n_out} = 4'hF;
		ad_out = 32'h0000_0000;
		cbe_n_out = 4'hF;
	end

	// One single-phase transfer; abort means nobody claims it
	task automatic xfer(input logic [31:0] a, input logic [3:0] cmd,
		input logic [31:0] d, input logic [3:0] be, input int waits,
		input bit abort);
		@(posedge clk_in);
		frame_n_out <= 1'b0;
		ad_out <= a;
		cbe_n_out <= ~cmd;
		@(posedge clk_in);
		frame_n_out <= ~abort;
		irdy_n_out <= 1'b0;
		ad_out <= d;
		cbe_n_out <= be;
		devsel_n_out <= abort;
		trdy_n_out <= abort || waits > 0;
		repeat (waits) @(posedge clk_in);
		if (waits > 0) trdy_n_out <= 1'b0;
		// Master gives up after the select window passes
		if (abort) begin
			repeat (4) @(posedge clk_in);
			frame_n_out <= 1'b1;
		end
		@(posedge clk_in);
		{irdy_n_out, trdy_n_out, devsel_n_out} <= 3'h7;
		ad_out <= ~d; // Released lines do not keep old data
		cbe_n_out <= ~be;
		@(posedge clk_in);
	endtask : xfer

	// Frame released, then driven low again inside one transaction
	task automatic frame_bounce(input logic [31:0] a, input logic [3:0] cmd);
		@(posedge clk_in);
		frame_n_out <= 1'b0;
		ad_out <= a;
		cbe_n_out <= ~cmd;
		@(posedge clk_in);
		frame_n_out <= 1'b1;
		irdy_n_out <= 1'b0;
		@(posedge clk_in);
		frame_n_out <= 1'b0;
		@(posedge clk_in);
		{frame_n_out, irdy_n_out} <= 2'h3;
		@(posedge clk_in);
	endtask : frame_bounce

	// Initiator ready asserted with no transaction open
	task automatic stray_ready();
		@(posedge clk_in);
		irdy_n_out <= 1'b0;
		@(posedge clk_in);
		irdy_n_out <= 1'b1;
		@(posedge clk_in);
	endtask : stray_ready
endmodule : bus_agent_model
`default_nettype wire

// File: tb/tb_palette_write_snoop.sv
// Self-checking bench for the palette write snooper
`timescale 1ns/100ps
`default_nettype none
module tb_palette_write_snoop
	import palette_snoop_pkg::*;
;
	logic              mclk_in, rst_n_in, en, clm, act;
	logic              fr_n, ir_n, tr_n, ds_n, cv, rc, wc, pe;
	logic [31:0]       ad;
	logic [3:0]        cbe_n;
	snoop_capture_type cap;
	int err_count = 0, compares = 0, cyc = 0;
	int nc = 0, nr = 0, nw = 0, ne = 0;

	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end

	// Pulse counters; also the hang guard
	always @(posedge mclk_in) begin
		cyc++;
		nc += (cv === 1'b1);
		nr += (rc === 1'b1);
		nw += (wc === 1'b1);
		ne += (pe === 1'b1);
		if (cyc == 3000) begin
			err_count++;
			test_done();
		end
	end

	bus_agent_model bus (.clk_in(mclk_in), .frame_n_out(fr_n),
		.irdy_n_out(ir_n), .trdy_n_out(tr_n), .devsel_n_out(ds_n),
		.ad_out(ad), .cbe_n_out(cbe_n));

	palette_write_snoop dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.frame_n_in(fr_n), .irdy_n_in(ir_n), .trdy_n_in(tr_n),
		.devsel_n_in(ds_n), .ad_in(ad), .cbe_n_in(cbe_n),
		.snoop_en_in(en), .write_claimer_in(clm),
		.adapter_active_in(act), .capture_out(cap),
		.capture_valid_out(cv), .read_claim_out(rc),
		.write_claim_out(wc), .protocol_err_out(pe));

	task automatic chk(input logic [68:0] got, input logic [68:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	// One transfer, then count pulses it caused
	task automatic run(input logic [31:0] a, input logic [3:0] c,
		input logic [31:0] d, input logic [3:0] be, input int w,
		input bit ab, output int dc, output int dr, output int dw);
		int c0, r0, w0;
		c0 = nc;
		r0 = nr;
		w0 = nw;
		bus.xfer(a, c, d, be, w, ab);
		repeat (2) @(posedge mclk_in);
		#1;
		dc = nc - c0;
		dr = nr - r0;
		dw = nw - w0;
	endtask : run

	task automatic t_capture();
		int dc, dr, dw;
		run(PAL_LO_ADDR, CMD_IO_WRITE, 32'hA5A5_1234, 4'h0, 0, 0, dc, dr, dw);
		chk(69'(dc), 69'h1);
		chk(cap, {PAL_LO_ADDR, 32'hA5A5_1234, 4'h0, 1'b0});
		run(PAL_HI_ADDR, CMD_IO_WRITE, 32'h0F0F_C3C3, 4'h6, 3, 0, dc, dr, dw);
		chk(69'(dc), 69'h1);
		chk(cap, {PAL_HI_ADDR, 32'h0F0F_C3C3, 4'h6, 1'b0});
		run(32'h0000_03C7, CMD_IO_WRITE, 32'h7E57_0001, 4'h9, 0, 1, dc, dr, dw);
		chk(69'(dc), 69'h1);
		chk(cap, {32'h0000_03C7, 32'h7E57_0001, 4'h9, 1'b1});
		$display("capture test done");
	endtask : t_capture

	task automatic t_ignore();
		logic [31:0] a [6] = '{32'h0000_03C5, 32'h0000_03CA, PAL_LO_ADDR,
			PAL_LO_ADDR, PAL_LO_ADDR, PAL_LO_ADDR};
		logic [3:0] c [6] = '{CMD_IO_WRITE, CMD_IO_WRITE, CMD_IO_READ,
			CMD_IO_WRITE, CMD_IO_WRITE, CMD_DUAL_ADR};
		int dc, dr, dw;
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk_in);
			en <= (i != 3);
			clm <= (i == 4);
			act <= (i == 2);
			run(a[i], c[i], 32'h1111_0000 + i, 4'h0, 0, 0, dc, dr, dw);
			chk(69'(dc), 69'h0);
			chk(69'(dw), 69'(i == 4));
			chk(69'(dr), 69'(i == 2));
		end
		@(posedge mclk_in);
		en <= 1'b1;
		clm <= 1'b0;
		act <= 1'b0;
		$display("ignore test done");
	endtask : t_ignore

	task automatic t_illegal();
		int c0, e0, dc, dr, dw;
		c0 = nc;
		e0 = ne;
		bus.stray_ready();
		repeat (2) @(posedge mclk_in);
		#1;
		chk(69'(ne - e0), 69'h1);
		chk(69'(nc - c0), 69'h0);
		// Armed palette write cut by a frame bounce: error, no capture
		e0 = ne;
		bus.frame_bounce(PAL_LO_ADDR, CMD_IO_WRITE);
		repeat (2) @(posedge mclk_in);
		#1;
		chk(69'(ne - e0), 69'h1);
		chk(69'(nc - c0), 69'h0);
		// Tracker must be back in idle and take the next write
		run(PAL_HI_ADDR, CMD_IO_WRITE, 32'h5A5A_0F0F, 4'h3, 1, 0, dc, dr, dw);
		chk(69'(dc), 69'h1);
		chk(cap, {PAL_HI_ADDR, 32'h5A5A_0F0F, 4'h3, 1'b0});
		$display("illegal test done");
	endtask : t_illegal

	task automatic test_done();
		$display("checks %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	initial begin
		rst_n_in = 1'b0;
		en = 1'b1;
		clm = 1'b0;
		act = 1'b0;
		repeat (2) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		#1;
		chk(cap, {32'h0, 32'h0, 4'hF, 1'b0});
		repeat (2) @(posedge mclk_in);
		t_capture();
		t_ignore();
		t_illegal();
		test_done();
	end
endmodule : tb_palette_write_snoop
`default_nettype wire
